// *** sim/icp_bank_model.sv ***
// Purpose: logical device banks behind the configuration port
// Assumes: rdata is sampled one cycle after the read strobe
// Notes:   unwritten places read zero
`timescale 1ns/1ns
module icp_bank_model (
	input wire logic       ref_clk,
	input wire logic [7:0] bank_ldn,
	input wire logic [7:0] bank_index,
	input wire logic [7:0] bank_wdata,
	input wire logic       bank_wr,
	input wire logic       bank_rd,
	output logic     [7:0] bank_rdata
);
	logic [7:0] mem [logic [15:0]];
	initial bank_rdata = 8'h00;
	// outside the answer cycle the bus toggles so stale data never matches
	always @(posedge ref_clk) begin
		if (bank_wr)
			mem[{bank_ldn, bank_index}] = bank_wdata;
		if (bank_rd)
			bank_rdata <= mem.exists({bank_ldn, bank_index}) ? mem[{bank_ldn, bank_index}] : 8'h00;
		else
			bank_rdata <= ~bank_rdata;
	end
endmodule

// *** sim/icp_config_port_properties.sv ***
// Purpose: pin-level checks of the configuration port
// Assumes: one clock, rst synchronous active high
// Notes:   bound onto every icp_config_port
`timescale 1ns/1ns
module icp_config_port_properties (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [15:0] io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_wdata,
	input wire logic        io_claim,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_rvalid,
	input wire logic [7:0]  ec_addr,
	input wire logic        ec_rd,
	input wire logic [7:0]  ec_rdata,
	input wire logic        ec_rvalid,
	input wire logic        bank_rd,
	input wire logic        cfg_open,
	input wire logic [15:0] port_base
);
	// ----
	// checks
	// ----
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic idx_hit;
	logic dat_hit;
	assign idx_hit = io_addr == port_base;
	assign dat_hit = io_addr == port_base + 16'h0001;
	chk_reset_leaves_locked: assert property ($fell(rst) |-> !cfg_open && port_base == 16'h002e)
		else $error("port not locked at base after reset");
	chk_unlock_key_opens: assert property (!cfg_open && io_wr && idx_hit && io_wdata == 8'h55 |=> cfg_open)
		else $error("unlock key did not open");
	chk_lock_key_closes: assert property (cfg_open && io_wr && idx_hit && io_wdata == 8'haa |=> !cfg_open)
		else $error("lock key did not close");
	chk_locked_stays_shut: assert property (!cfg_open && !(io_wr && idx_hit && io_wdata == 8'h55) |=> !cfg_open)
		else $error("opened without unlock key");
	chk_claim_decode: assert property (io_claim == ((io_wr || io_rd) && (idx_hit || dat_hit)))
		else $error("claim does not match port decode");
	chk_locked_read_zero: assert property (!cfg_open && io_rd && (idx_hit || dat_hit) |=> io_rvalid && io_rdata == 8'h00)
		else $error("locked read not answered with zero");
	chk_ctrl_read_answer: assert property (ec_rd |=> ec_rvalid)
		else $error("controller read not answered");
	chk_ctrl_reserved_zero: assert property (ec_rd && ec_addr inside {[8'h08:8'h18]} |=> ec_rdata == 8'h00)
		else $error("reserved location not zero");
	chk_bank_read_latency: assert property (bank_rd |-> ##2 io_rvalid)
		else $error("bank read answer late or missing");
	chk_answer_has_cause: assert property (io_rvalid |-> $past(io_rd) || $past(io_rd, 3))
		else $error("read answer without request");
endmodule
bind icp_config_port icp_config_port_properties u_props (.ref_clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata,
	.io_claim, .io_rdata, .io_rvalid, .ec_addr, .ec_rd, .ec_rdata, .ec_rvalid, .bank_rd, .cfg_open, .port_base);

// *** sim/testbench.sv ***
// Purpose: self-checking bench of the configuration port
// Assumes: host, controller and reset pins driven at rising edges
// Notes:   id values set here are arbitrary
`timescale 1ns/1ns
`include "icp_defines.svh"
module testbench;
	localparam logic [15:0] DID = 16'h1234; // arbitrary
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        supply_off = 1'b0;
	logic        if_reset = 1'b0;
	logic [15:0] io_addr = 16'h0000;
	logic        io_wr = 1'b0;
	logic        io_rd = 1'b0;
	logic [7:0]  io_wdata = 8'h00;
	logic [7:0]  ec_addr = 8'h00;
	logic        ec_wr = 1'b0;
	logic        ec_rd = 1'b0;
	logic [7:0]  ec_wdata = 8'h00;
	logic [7:0]  io_rdata, ec_rdata, bank_ldn, bank_index, bank_wdata, bank_rdata;
	logic        io_claim, io_rvalid, ec_rvalid, bank_wr, bank_rd, cfg_open;
	logic [15:0] port_base;
	logic [15:0] base = 16'h002e;
	int          mismatches = 0;
	int          total_checks = 0;
	icp_config_port #(.REV_VALUE(8'h01), .SUBID_VALUE(8'h02), .DEVID_VALUE(DID), .LEGACY_VALUE(8'h5a))
	u_icp_config_port (.ref_clk, .rst, .main_supply_off(supply_off), .host_if_reset(if_reset), .io_addr, .io_wr,
		.io_rd, .io_wdata, .io_claim, .io_rdata, .io_rvalid, .ec_addr, .ec_wr, .ec_rd, .ec_wdata, .ec_rdata,
		.ec_rvalid, .bank_ldn, .bank_index, .bank_wdata, .bank_wr, .bank_rd, .bank_rdata, .cfg_open, .port_base);
	icp_bank_model u_icp_bank_model (.ref_clk, .bank_ldn, .bank_index, .bank_wdata, .bank_wr, .bank_rd, .bank_rdata);
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	// ----
	// bus tasks
	// ----
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge ref_clk);
		io_wr <= 1'b0;
	endtask
	task automatic io_read(input logic [15:0] a, input logic [7:0] exp, input string what);
		int n;
		@(posedge ref_clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge ref_clk);
		io_rd <= 1'b0;
		#1;
		for (n = 0; n < 8 && io_rvalid !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (n == 8) begin
			check("read answer", 16'h0001, 16'h0000);
			print_verdict();
		end
		check(what, {8'h00, exp}, {8'h00, io_rdata});
	endtask
	task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
		io_write(base, idx);
		io_write(base + 16'h0001, d);
	endtask
	task automatic ec_access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		ec_addr <= a;
		ec_wdata <= d;
		ec_wr <= wr;
		ec_rd <= !wr;
		@(posedge ref_clk);
		ec_wr <= 1'b0;
		ec_rd <= 1'b0;
		#1;
		if (!wr)
			check("ec data", {8'h01, d}, {7'h00, ec_rvalid, ec_rdata});
	endtask
	// ----
	// scenarios
	// ----
	task automatic s_locked();
		check("open", 16'h0000, {15'h0000, cfg_open});
		check("base", 16'h002e, port_base);
		cfg(`ICP_IDX_LDN, 8'h33);
		io_read(base + 16'h0001, 8'h00, "locked data");
		io_write(base, `ICP_KEY_UNLOCK);
		io_read(base, 8'h00, "pointer");
		io_read(base + 16'h0001, 8'h00, "location zero");
		cfg(`ICP_IDX_LDN, 8'h3f);
		io_read(base + 16'h0001, 8'h3f, "ldn");
	endtask
	task automatic s_globals();
		// vendor test locations are left alone on purpose
		logic [7:0] rsv [7] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h08, 8'h18, 8'h24};
		logic [7:0] ids [5] = '{8'h01, 8'h02, DID[7:0], DID[15:8], 8'h5a};
		foreach (rsv[i]) begin
			cfg(rsv[i], 8'hff);
			io_read(base + 16'h0001, 8'h00, "reserved");
		end
		foreach (ids[i]) begin
			cfg(`ICP_IDX_REV + 8'(i), 8'h99);
			io_read(base + 16'h0001, ids[i], "id");
		end
	endtask
	task automatic s_bank();
		cfg(`ICP_IDX_LDN, 8'h08);
		cfg(8'h34, 8'h02);
		io_read(base + 16'h0001, 8'h02, "bank");
		io_write(base, `ICP_IDX_ID_LO);
		io_read(base + 16'h0001, DID[7:0], "global in bank");
		cfg(`ICP_IDX_LDN, 8'h09);
		cfg(8'h34, 8'h00);
		cfg(`ICP_IDX_LDN, 8'h08);
		io_write(base, 8'h34);
		io_read(base + 16'h0001, 8'h02, "bank kept");
	endtask
	task automatic s_relocate();
		cfg(`ICP_IDX_LDN, `ICP_LDN_PORT);
		cfg(`ICP_IDX_BAR_HI, 8'h00);
		cfg(`ICP_IDX_BAR_LO, 8'h4e);
		base = 16'h004e;
		#1;
		check("moved base", base, port_base);
		io_write(base, `ICP_KEY_LOCK);
		#1;
		check("locked", 16'h0000, {15'h0000, cfg_open});
		io_write(base + 16'h0001, 8'h77);
		io_write(base, `ICP_KEY_UNLOCK);
		io_read(base, `ICP_IDX_BAR_LO, "pointer kept");
		io_read(base + 16'h0001, 8'h4e, "bar kept");
	endtask
	task automatic s_host_reset(input logic by_supply);
		io_write(base, `ICP_KEY_UNLOCK);
		supply_off <= by_supply;
		if_reset <= !by_supply;
		repeat (5) @(posedge ref_clk);
		supply_off <= 1'b0;
		if_reset <= 1'b0;
		#1;
		check("host reset", {base, 1'b0}, {port_base, cfg_open});
		// synchronised host reset lingers for two edges after the pins drop
		repeat (3) @(posedge ref_clk);
		io_write(base, `ICP_KEY_UNLOCK);
		io_read(base, 8'h00, "pointer cleared");
	endtask
	task automatic s_controller();
		ec_access(1'b0, `ICP_IDX_ID_HI, DID[15:8]);
		ec_access(1'b1, `ICP_IDX_LDN, 8'h05);
		ec_access(1'b0, `ICP_IDX_LDN, 8'h05);
		ec_access(1'b1, 8'h10, 8'hff);
		ec_access(1'b0, 8'h10, 8'h00);
		io_write(base, `ICP_IDX_LDN);
		io_read(base + 16'h0001, 8'h05, "shared ldn");
		io_write(base, `ICP_KEY_LOCK);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		check("sys reset", 16'h005c, {port_base[14:0], cfg_open});
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		s_locked();
		s_globals();
		s_bank();
		s_relocate();
		s_host_reset(1'b0);
		s_host_reset(1'b1);
		s_controller();
		print_verdict();
	end
endmodule

// *** verilog/icp_access_ctl.sv ***
// Purpose: configuration access state and index pointer
// Assumes: idx_wr is a one-cycle strobe for a host write to the index port
// Notes:   keys act only from the opposite state
`timescale 1ns/1ns
`include "icp_defines.svh"
module icp_access_ctl (
	input  wire logic ref_clk,
	input  wire logic rst,
	icp_if.ctl        bus
);
	icp_pkg::icp_ctl_st_t st_ff;
	icp_pkg::icp_ctl_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (bus.idx_wr) begin
			if (st_ff.mode == icp_pkg::ICP_LOCKED) begin
				if (bus.wdata == `ICP_KEY_UNLOCK) begin
					nxt_st.mode = icp_pkg::ICP_OPEN; // [R06]
				end
			end else if (bus.wdata == `ICP_KEY_LOCK) begin
				nxt_st.mode = icp_pkg::ICP_LOCKED; // [R07]
			end else begin
				nxt_st.ptr = bus.wdata; // [R24] [R02]
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || bus.host_reset) begin
			st_ff <= '{mode: icp_pkg::ICP_LOCKED, ptr: `ICP_PTR_RESET}; // [R01] [R08] [R03]
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign bus.mode = st_ff.mode;
	assign bus.ptr  = st_ff.ptr;
endmodule

// *** verilog/icp_config_port.sv ***
// Purpose: index/data configuration port with global and per-device banks
// Assumes: host I/O strobes and device bank answers share ref_clk
// Notes:   rst is the power-on system reset; host reset arrives as pins
//
// Operation
// [R01] access state is disabled after reset; locked data reads are undefined
// [R02] index port holds a pointer; data port reaches the pointed location
// [R03] pointer resets to zero so first data read returns location zero
// [R04] index at base plus zero, data at base plus one, base 002Eh
// [R05] base address relocates through bar of logical device Ch
// [R06] unlock key 55h at index port enables access when disabled
// [R07] lock key AAh at index port disables access when enabled
// [R08] system reset or host reset forces access disabled
// [R09] ports act only while enabled; otherwise only the unlock key counts
// [R10] host enables access, programs registers, then disables access
// [R11] 48 global locations 00h-2Fh reachable whatever device is selected
// [R12] each logical device has up to 208 locations
// [R13] global 07h holds device number selecting the reachable bank
// [R14] host selects device through 07h then indexes the bank
// [R15] device number 3Fh gives global access with global indices
// [R16] embedded controller reaches globals directly by memory offset
// [R17] reserved globals ignore writes and read zero
// [R18] 1Ch-1Fh read-only revision, sub id and 16-bit device id
// [R19] 20h read-only legacy identification byte
// [R20] host must leave vendor test locations unchanged
// [R21] block raises no interrupt
// [R22] selected device bank appears at indices 30h-FFh
// [R23] host reset when supply is off or host resets its interface
// [R24] enabled index writes other than lock load the pointer
`timescale 1ns/1ns
`include "icp_defines.svh"
module icp_config_port #(
	parameter logic [7:0]  REV_VALUE    = 8'h01, // arbitrary
	parameter logic [7:0]  SUBID_VALUE  = 8'h02, // arbitrary
	parameter logic [15:0] DEVID_VALUE  = 16'h1234, // arbitrary
	parameter logic [7:0]  LEGACY_VALUE = 8'h5a // arbitrary
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        main_supply_off,
	input  wire logic        host_if_reset,
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic             io_claim,
	output logic [7:0]       io_rdata,
	output logic             io_rvalid,
	input  wire logic [7:0]  ec_addr,
	input  wire logic        ec_wr,
	input  wire logic        ec_rd,
	input  wire logic [7:0]  ec_wdata,
	output logic [7:0]       ec_rdata,
	output logic             ec_rvalid,
	output logic [7:0]       bank_ldn,
	output logic [7:0]       bank_index,
	output logic [7:0]       bank_wdata,
	output logic             bank_wr,
	output logic             bank_rd,
	input  wire logic [7:0]  bank_rdata,
	output logic             cfg_open,
	output logic [15:0]      port_base
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// vendor test locations keep what is written; host must not touch them
	function automatic logic is_test(input logic [7:0] idx);
		is_test = (idx == `ICP_IDX_TEST_A) ||
			(idx >= `ICP_IDX_TEST_B && idx <= `ICP_IDX_TEST_B_E) ||
			(idx >= `ICP_IDX_TEST_C && idx <= `ICP_IDX_GLOB_END); // [R20]
	endfunction

	function automatic logic is_global(input logic [7:0] idx);
		is_global = idx < `ICP_IDX_BANK; // [R11]
	endfunction

	function automatic logic glob_writable(input logic [7:0] idx);
		glob_writable = (idx == `ICP_IDX_LDN) || is_test(idx); // [R17] [R18] [R19]
	endfunction

	function automatic logic [7:0] glob_read(input logic [47:0][7:0] g, input logic [7:0] idx);
		case (idx)
			`ICP_IDX_REV:    glob_read = REV_VALUE; // [R18]
			`ICP_IDX_SUBID:  glob_read = SUBID_VALUE;
			`ICP_IDX_ID_LO:  glob_read = DEVID_VALUE[7:0];
			`ICP_IDX_ID_HI:  glob_read = DEVID_VALUE[15:8];
			`ICP_IDX_LEGACY: glob_read = LEGACY_VALUE; // [R19]
			default: begin
				if (glob_writable(idx)) begin
					glob_read = g[idx[5:0]];
				end else begin
					glob_read = `ICP_BYTE_ZERO; // [R17]
				end
			end
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state and submodules
	// ----------------------------------------------------------------
	icp_pkg::icp_top_st_t st_ff;
	icp_pkg::icp_top_st_t nxt_st;
	icp_if                acc ();
	logic                 host_reset;
	logic [15:0]          base;
	logic                 hit_index;
	logic                 hit_data;
	logic                 open;
	logic [7:0]           ptr;
	logic [7:0]           ldn;
	logic                 port_bar;

	icp_reset_sync u_sync (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.main_supply_off (main_supply_off),
		.host_if_reset   (host_if_reset),
		.host_reset      (host_reset)
	);

	icp_access_ctl u_ctl (
		.ref_clk (ref_clk),
		.rst     (rst),
		.bus     (acc.ctl)
	);

	// ----------------------------------------------------------------
	// host decode
	// ----------------------------------------------------------------
	assign base      = {st_ff.bar_hi, st_ff.bar_lo}; // [R05]
	assign hit_index = io_addr == base + `ICP_OFS_INDEX; // [R04]
	assign hit_data  = io_addr == base + `ICP_OFS_DATA;
	assign io_claim  = (io_wr || io_rd) && (hit_index || hit_data);

	assign acc.idx_wr     = io_wr && hit_index;
	assign acc.wdata      = io_wdata;
	assign acc.host_reset = host_reset; // [R08]
	assign open           = acc.mode == icp_pkg::ICP_OPEN;
	assign ptr            = acc.ptr;
	assign ldn            = st_ff.glob[`ICP_IDX_LDN]; // [R13]
	assign port_bar       = (ldn == `ICP_LDN_PORT) &&
		(ptr == `ICP_IDX_BAR_HI || ptr == `ICP_IDX_BAR_LO); // [R05]

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st           = st_ff;
		nxt_st.io_rvalid = 1'b0;
		nxt_st.ec_rvalid = 1'b0;
		nxt_st.bank_wr   = 1'b0;
		nxt_st.bank_rd   = 1'b0;

		// device bank answer arrives one cycle after the request
		if (st_ff.io_bank_wait) begin
			nxt_st.io_bank_wait = 1'b0;
			nxt_st.io_rdata     = bank_rdata; // [R22]
			nxt_st.io_rvalid    = 1'b1;
		end

		// embedded controller path needs no unlock
		if (ec_wr && ec_addr < `ICP_IDX_BANK && glob_writable(ec_addr)) begin
			nxt_st.glob[ec_addr[5:0]] = ec_wdata; // [R16]
		end
		if (ec_rd) begin
			nxt_st.ec_rvalid = 1'b1;
			nxt_st.ec_rdata  = is_global(ec_addr) ? glob_read(st_ff.glob, ec_addr) : `ICP_BYTE_ZERO; // [R16]
		end

		// host index port read shows pointer only while enabled
		if (io_rd && hit_index) begin
			nxt_st.io_rvalid = 1'b1;
			nxt_st.io_rdata  = open ? ptr : `ICP_BYTE_ZERO; // [R09]
		end

		// host data port; host wins over a same-cycle controller write
		if (hit_data && (io_wr || io_rd)) begin
			if (!open) begin
				if (io_rd) begin
					nxt_st.io_rvalid = 1'b1;
					nxt_st.io_rdata  = `ICP_BYTE_ZERO; // [R01] [R09]
				end
			end else if (is_global(ptr)) begin
				if (io_wr && glob_writable(ptr)) begin
					nxt_st.glob[ptr[5:0]] = io_wdata; // [R02] [R11]
				end
				if (io_rd) begin
					nxt_st.io_rvalid = 1'b1;
					nxt_st.io_rdata  = glob_read(st_ff.glob, ptr); // [R02]
				end
			end else if (port_bar) begin
				if (io_wr && ptr == `ICP_IDX_BAR_HI) begin
					nxt_st.bar_hi = io_wdata; // [R05]
				end
				if (io_wr && ptr == `ICP_IDX_BAR_LO) begin
					nxt_st.bar_lo = io_wdata;
				end
				if (io_rd) begin
					nxt_st.io_rvalid = 1'b1;
					nxt_st.io_rdata  = (ptr == `ICP_IDX_BAR_HI) ? st_ff.bar_hi : st_ff.bar_lo;
				end
			end else if (ldn == `ICP_LDN_GLOBAL) begin
				// global view has no bank above 2Fh
				if (io_rd) begin
					nxt_st.io_rvalid = 1'b1;
					nxt_st.io_rdata  = `ICP_BYTE_ZERO; // [R15]
				end
			end else begin
				nxt_st.bank_ldn   = ldn; // [R22] [R12]
				nxt_st.bank_index = ptr;
				nxt_st.bank_wdata = io_wdata;
				nxt_st.bank_wr    = io_wr;
				nxt_st.bank_rd    = io_rd;
			end
		end
		if (st_ff.bank_rd) begin
			nxt_st.io_bank_wait = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_ff        <= '0;
			st_ff.bar_hi <= 8'(`ICP_BASE_RESET >> 8); // [R04]
			st_ff.bar_lo <= 8'(`ICP_BASE_RESET);
			st_ff.glob[`ICP_IDX_LDN] <= `ICP_LDN_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs; there is no interrupt output at all
	// ----------------------------------------------------------------
	assign io_rdata   = st_ff.io_rdata; // [R21]
	assign io_rvalid  = st_ff.io_rvalid;
	assign ec_rdata   = st_ff.ec_rdata;
	assign ec_rvalid  = st_ff.ec_rvalid;
	assign bank_ldn   = st_ff.bank_ldn;
	assign bank_index = st_ff.bank_index;
	assign bank_wdata = st_ff.bank_wdata;
	assign bank_wr    = st_ff.bank_wr;
	assign bank_rd    = st_ff.bank_rd;
	assign cfg_open   = open;
	assign port_base  = base;
endmodule

// *** verilog/icp_defines.svh ***
// Purpose: named constants of the indexed configuration port
// Assumes: 8-bit locations, 16-bit host I/O addresses
// Notes:   header only, no logic
`ifndef ICP_DEFINES_SVH
`define ICP_DEFINES_SVH

// ----------------------------------------------------------------
// keys and port layout
// ----------------------------------------------------------------
`define ICP_KEY_UNLOCK   8'h55
`define ICP_KEY_LOCK     8'haa
`define ICP_OFS_INDEX    16'h0000
`define ICP_OFS_DATA     16'h0001
`define ICP_BASE_RESET   16'h002e
`define ICP_PTR_RESET    8'h00
`define ICP_BYTE_ZERO    8'h00

// ----------------------------------------------------------------
// global locations
// ----------------------------------------------------------------
`define ICP_GLOBAL_COUNT 48
`define ICP_IDX_LDN      8'h07
`define ICP_IDX_TEST_A   8'h02
`define ICP_IDX_REV      8'h1c
`define ICP_IDX_SUBID    8'h1d
`define ICP_IDX_ID_LO    8'h1e
`define ICP_IDX_ID_HI    8'h1f
`define ICP_IDX_LEGACY   8'h20
`define ICP_IDX_TEST_B   8'h22
`define ICP_IDX_TEST_B_E 8'h23
`define ICP_IDX_TEST_C   8'h25
`define ICP_IDX_GLOB_END 8'h2f
`define ICP_IDX_BANK     8'h30
`define ICP_LDN_RESET    8'h00

// ----------------------------------------------------------------
// logical devices
// ----------------------------------------------------------------
`define ICP_LDN_GLOBAL   8'h3f
`define ICP_LDN_PORT     8'h0c
`define ICP_IDX_BAR_HI   8'h60
`define ICP_IDX_BAR_LO   8'h61

`endif

// *** verilog/icp_if.sv ***
// Purpose: carrier between the port core and its access control
// Assumes: one clock, ref_clk
// Notes:   core drives strobes, control answers with mode and pointer
`timescale 1ns/1ns
interface icp_if;
	logic                 idx_wr;
	logic [7:0]           wdata;
	logic                 host_reset;
	icp_pkg::icp_mode_t   mode;
	logic [7:0]           ptr;

	modport core (output idx_wr, output wdata, output host_reset, input mode, input ptr);
	modport ctl  (input idx_wr, input wdata, input host_reset, output mode, output ptr);
endinterface

// *** verilog/icp_pkg.sv ***
// Purpose: types of the indexed configuration port
// Assumes: constants live in icp_defines.svh
// Notes:   state of each module is one packed struct
package icp_pkg;

	typedef enum logic [0:0] {
		ICP_LOCKED = 1'b0,
		ICP_OPEN   = 1'b1
	} icp_mode_t;

	typedef struct packed {
		icp_mode_t  mode;
		logic [7:0] ptr;
	} icp_ctl_st_t;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} icp_sync_st_t;

	typedef struct packed {
		logic [47:0][7:0] glob;
		logic [7:0]       bar_hi;
		logic [7:0]       bar_lo;
		logic [7:0]       io_rdata;
		logic             io_rvalid;
		logic             io_bank_wait;
		logic [7:0]       ec_rdata;
		logic             ec_rvalid;
		logic [7:0]       bank_ldn;
		logic [7:0]       bank_index;
		logic [7:0]       bank_wdata;
		logic             bank_wr;
		logic             bank_rd;
	} icp_top_st_t;

endpackage

// *** verilog/icp_reset_sync.sv ***
// Purpose: bring the host reset causes into the ref_clk domain
// Assumes: both causes are asynchronous levels, active high
// Notes:   output is high while either synchronised cause is high
`timescale 1ns/1ns
module icp_reset_sync (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic main_supply_off,
	input  wire logic host_if_reset,
	output logic      host_reset
);
	icp_pkg::icp_sync_st_t st_ff;
	icp_pkg::icp_sync_st_t nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = {main_supply_off, host_if_reset};
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// either cause counts as host reset
	assign host_reset = |st_ff.s2; // [R23]
endmodule
